// ==== logic/option_byte_config_loader.sv ====
/*
 Option byte loader: fetches five configuration bytes after reset,
 latches the settings, filters flash writes and gates core reset.
 Assumes a byte flash read port on pclk answering with a one-cycle
 valid pulse, an APB master on pclk, and async supply comparators.
*/
`timescale 1ns/10ps
`default_nettype none
module option_byte_config_loader #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic boot_swap,
	input wire logic self_prog,
	output logic fl_rd_req,
	output logic [15:0] fl_rd_addr,
	input wire logic [7:0] fl_rd_data,
	input wire logic fl_rd_valid,
	input wire logic wr_in_req,
	input wire logic [15:0] wr_in_addr,
	input wire logic [7:0] wr_in_data,
	input wire logic wr_in_ext,
	output logic fl_wr_req,
	output logic [15:0] fl_wr_addr,
	output logic [7:0] fl_wr_data,
	input wire logic supply_above_hi,
	input wire logic supply_above_lo,
	output logic power_on_clear,
	output logic core_reset_n,
	output logic slow_osc_stop_lock,
	output logic slow_osc_stop,
	output logic [2:0] wd_interval,
	output logic watchdog_counter_on,
	output logic wd_window_sel_hi,
	output logic wd_window_sel_lo,
	output logic poweron_clear_threshold_select,
	output logic debug_enable_hi,
	output logic debug_enable_lo,
	output logic debug_erase_on_fail
);
	typedef struct packed {
		option_loader_pkg::load_state_type st;
		logic [2:0] idx;
		logic swap;
		logic self;
		logic [4:0][7:0] opt;
		logic done;
		logic rd_req;
		logic [15:0] rd_addr;
		logic wr_req;
		logic [15:0] wr_addr;
		logic [7:0] wr_data;
		logic slow_osc_stop_request;
		logic osc_stop;
		logic blocked;
		logic core_rst_n;
		logic lock;
		logic [2:0] wdi;
		logic wdon;
		logic win_hi;
		logic win_lo;
		logic pocsel;
		logic dbg_hi;
		logic dbg_lo;
		logic dbg_erase;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_type;
	state_type q, d;
	logic [1:0] cmp_s;
	logic clr_hold;
	logic [15:0] base;
	logic [2:0] sel;
	logic setup;
	logic access;

	initial begin
		if (ADDR_W < 4 || ADDR_W > 16) $error("ADDR_W out of range");
	end

	// Register select: {valid, index}; shared by read and write paths
	function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] a);
		logic [11:0] w;
		w = 12'(a);
		if (a != ADDR_W'(w)) begin
			reg_decode = 3'b000;
		end else if (w == option_loader_pkg::REG_STATUS) begin
			reg_decode = 3'b100;
		end else if (w == option_loader_pkg::REG_CONTROL) begin
			reg_decode = 3'b101;
		end else if (w == option_loader_pkg::REG_OPT_LO) begin
			reg_decode = 3'b110;
		end else if (w == option_loader_pkg::REG_OPT_HI) begin
			reg_decode = 3'b111;
		end else begin
			reg_decode = 3'b000;
		end
	endfunction

	// Supply comparator pins cross into pclk
	pin_sync #(
		.W(2)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d({supply_above_hi, supply_above_lo}),
		.q(cmp_s)
	);

	// Threshold sequencer, fed once the mode is latched
	clear_monitor u_clr (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.above_hi(cmp_s[1]),
		.above_lo(cmp_s[0]),
		.dual_mode(q.pocsel),
		.mode_valid(q.done),
		.hold(clr_hold)
	);

	// Fetch area follows the boot swap strap
	assign base = q.swap ? option_loader_pkg::OPT_MIRROR
		: option_loader_pkg::OPT_PRIMARY;
	assign sel = reg_decode(paddr);
	assign setup = psel && !penable;
	assign access = psel && penable && q.pready;

	// Loader sequence, write filter and APB slave
	always_comb begin
		d = q;
		d.rd_req = 1'b0;
		d.wr_req = 1'b0;
		d.core_rst_n = 1'b0;
		case (q.st)
			option_loader_pkg::LD_STRAP: begin
				d.swap = boot_swap;
				d.self = self_prog;
				d.idx = option_loader_pkg::IDX_WD;
				d.st = option_loader_pkg::LD_REQ;
			end
			option_loader_pkg::LD_REQ: begin
				d.rd_req = 1'b1;
				d.rd_addr = base + {13'h0000, q.idx};
				d.st = option_loader_pkg::LD_WAIT;
			end
			option_loader_pkg::LD_WAIT: begin
				if (fl_rd_valid) begin
					d.opt[q.idx] = fl_rd_data;
					if (q.idx == option_loader_pkg::IDX_DBG) begin
						d.done = 1'b1;
						d.st = q.swap ? option_loader_pkg::LD_COPY
							: option_loader_pkg::LD_RUN;
					end else begin
						d.idx = q.idx + 3'h1;
						d.st = option_loader_pkg::LD_REQ;
					end
				end
			end
			option_loader_pkg::LD_COPY: begin
				d.wr_req = 1'b1;
				d.wr_addr = option_loader_pkg::OPT_THR_ADDR;
				d.wr_data = q.opt[option_loader_pkg::IDX_THR];
				d.st = option_loader_pkg::LD_RUN;
			end
			default: begin
				d.core_rst_n = !clr_hold;
			end
		endcase
		// Latch every field once the last byte lands
		if (q.st == option_loader_pkg::LD_WAIT && fl_rd_valid
			&& q.idx == option_loader_pkg::IDX_DBG) begin
			d.lock = q.opt[0][option_loader_pkg::WD_LOCK_BIT];
			d.wdi = q.opt[0][option_loader_pkg::WD_INT_LSB +: 3];
			d.wdon = q.opt[0][option_loader_pkg::WD_ON_BIT];
			d.win_hi = q.opt[0][option_loader_pkg::WD_WIN_HI_BIT];
			d.win_lo = q.opt[0][option_loader_pkg::WD_WIN_LO_BIT];
			d.pocsel = !q.self
				&& q.opt[1][option_loader_pkg::THR_MODE_BIT];
			d.dbg_hi = fl_rd_data[option_loader_pkg::DBG_HI_BIT];
			d.dbg_lo = fl_rd_data[option_loader_pkg::DBG_LO_BIT];
			d.dbg_erase = fl_rd_data[option_loader_pkg::DBG_HI_BIT]
				&& fl_rd_data[option_loader_pkg::DBG_LO_BIT];
		end
		// Oscillator stop honours the lock
		d.osc_stop = q.slow_osc_stop_request && !q.lock;
		// APB: zero-wait answer one cycle after setup
		d.pready = setup && !q.pready;
		d.pslverr = 1'b0;
		d.prdata = 32'h0000_0000;
		if (setup && !q.pready) begin
			if (!sel[2] || (pwrite && sel[1])) begin
				d.pslverr = 1'b1;
			end else if (!pwrite) begin
				case (sel[1:0])
					2'b00: begin
						d.prdata[option_loader_pkg::STS_DONE_BIT] = q.done;
						d.prdata[option_loader_pkg::STS_SWAP_BIT] = q.swap;
						d.prdata[option_loader_pkg::STS_SELF_BIT] = q.self;
						d.prdata[option_loader_pkg::STS_CLR_BIT] = clr_hold;
						d.prdata[option_loader_pkg::STS_RSV_BIT] =
							|{q.opt[2], q.opt[3]};
						d.prdata[option_loader_pkg::STS_BLK_BIT] = q.blocked;
						d.prdata[option_loader_pkg::STS_DBGBAD_BIT] =
							!q.dbg_hi && q.dbg_lo;
					end
					2'b01: d.prdata[option_loader_pkg::CTRL_STOP_BIT] =
						q.slow_osc_stop_request;
					2'b10: d.prdata = {q.opt[3], q.opt[2], q.opt[1], q.opt[0]};
					default: d.prdata = {24'h000000, q.opt[4]};
				endcase
			end
		end
		if (access && pwrite && !q.pslverr) begin
			if (sel[1:0] == 2'b00
				&& pwdata[option_loader_pkg::STS_BLK_BIT]) begin
				d.blocked = 1'b0;
			end else if (sel[1:0] == 2'b01) begin
				d.slow_osc_stop_request =
					pwdata[option_loader_pkg::CTRL_STOP_BIT];
			end
		end
		// Write filter; threshold byte only from the programmer path
		if (q.st != option_loader_pkg::LD_COPY && wr_in_req) begin
			if (wr_in_addr == option_loader_pkg::OPT_THR_ADDR
				&& !wr_in_ext) begin
				d.blocked = 1'b1;
			end else begin
				d.wr_req = 1'b1;
				d.wr_addr = wr_in_addr;
				d.wr_data = wr_in_data;
			end
		end
	end

	// State register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{st: option_loader_pkg::LD_STRAP, idx: 3'h0,
				opt: {5{option_loader_pkg::BYTE_RESET}},
				rd_addr: 16'h0000, wr_addr: 16'h0000,
				wr_data: 8'h00, wdi: 3'h0, prdata: 32'h0000_0000,
				default: 1'b0};
		end else if (ce) begin
			q <= d;
		end
	end

	// Outputs straight from flops
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign fl_rd_req = q.rd_req;
	assign fl_rd_addr = q.rd_addr;
	assign fl_wr_req = q.wr_req;
	assign fl_wr_addr = q.wr_addr;
	assign fl_wr_data = q.wr_data;
	assign power_on_clear = clr_hold;
	assign core_reset_n = q.core_rst_n;
	assign slow_osc_stop_lock = q.lock;
	assign slow_osc_stop = q.osc_stop;
	assign wd_interval = q.wdi;
	assign watchdog_counter_on = q.wdon;
	assign wd_window_sel_hi = q.win_hi;
	assign wd_window_sel_lo = q.win_lo;
	assign poweron_clear_threshold_select = q.pocsel;
	assign debug_enable_hi = q.dbg_hi;
	assign debug_enable_lo = q.dbg_lo;
	assign debug_erase_on_fail = q.dbg_erase;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_fetch_range: assert property (
		fl_rd_req |-> fl_rd_addr - base <= 16'h0004)
		else $error("fetch outside option area");
	a_mirror_sel: assert property (
		fl_rd_req |-> fl_rd_addr[12] == q.swap)
		else $error("fetch area does not follow boot swap");
	// Sampled reset keeps the release edge itself out of the antecedent
	a_auto_start: assert property (
		presetn && ce && q.st == option_loader_pkg::LD_STRAP
		##1 ce |=> fl_rd_req && fl_rd_addr == base)
		else $error("fetch did not start after reset");
	a_stop_gate: assert property (
		ce && q.lock |=> !slow_osc_stop)
		else $error("locked oscillator stopped");
	a_thr_wr_gate: assert property (
		ce && wr_in_req && !wr_in_ext
		&& wr_in_addr == option_loader_pkg::OPT_THR_ADDR
		&& q.st != option_loader_pkg::LD_COPY |=> !fl_wr_req)
		else $error("threshold byte write passed without programmer");
	a_copy_thr: assert property (
		ce && q.st == option_loader_pkg::LD_COPY
		|=> fl_wr_req && fl_wr_addr == option_loader_pkg::OPT_THR_ADDR
		&& fl_wr_data == $past(q.opt[1]))
		else $error("boot swap copy of threshold byte wrong");
	a_self_default: assert property (
		q.done && q.self |-> !poweron_clear_threshold_select)
		else $error("dual mode applied under self-programming");
	a_rel_after_load: assert property (
		core_reset_n
		|-> q.done && !$past(q.st == option_loader_pkg::LD_WAIT))
		else $error("core released before fields latched");
	a_cfg_hold: assert property (
		core_reset_n ##1 core_reset_n
		|-> $stable(wd_interval) && $stable(debug_enable_hi)
		&& $stable(poweron_clear_threshold_select))
		else $error("configuration changed while running");
	a_dbg_decode: assert property (
		q.done |-> debug_erase_on_fail
		== (debug_enable_hi && debug_enable_lo))
		else $error("debug erase decode wrong");
	a_apb_ready: assert property (ce && setup && !q.pready |=> pready)
		else $error("APB answer late");
	c_swap_load: cover property (q.swap && core_reset_n);
	c_blocked_wr: cover property ($rose(q.blocked));
	c_apb_write: cover property (access && pwrite && !pslverr);
endmodule
`default_nettype wire

// ==== logic/pin_sync.sv ====
/*
 Two-flop synchroniser for asynchronous level inputs.
 Assumes the inputs are slow levels; no pulse capture.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_type;
	sync_type r_q, r_d;

	initial begin
		if (W < 1) $error("pin_sync: W must be at least 1");
	end

	// First stage feeds only the second
	always_comb begin
		r_d = r_q;
		r_d.s1 = d;
		r_d.s2 = r_q.s1;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '0;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	assign q = r_q.s2;
endmodule
`default_nettype wire

// ==== logic/poc_monitor.sv ====
/*
 Power-on-clear threshold sequencer.
 Assumes synchronised comparator levels and a mode valid once loaded.
*/
`timescale 1ns/10ps
`default_nettype none
module clear_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic above_hi,
	input wire logic above_lo,
	input wire logic dual_mode,
	input wire logic mode_valid,
	output logic hold
);
	typedef struct packed {
		option_loader_pkg::clr_state_type st;
		logic hold;
	} clr_type;
	clr_type r_q, r_d;

	// Hold until the selected threshold, then watch the lower one
	always_comb begin
		r_d = r_q;
		case (r_q.st)
			option_loader_pkg::CLR_HOLD: begin
				r_d.hold = 1'b1;
				if (mode_valid && (dual_mode ? above_hi : above_lo)) begin
					r_d.st = option_loader_pkg::CLR_RUN;
					r_d.hold = 1'b0;
				end
			end
			default: begin
				if (!above_lo) begin
					r_d.st = option_loader_pkg::CLR_HOLD;
					r_d.hold = 1'b1;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '{st: option_loader_pkg::CLR_HOLD, hold: 1'b1};
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	assign hold = r_q.hold;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_dual_hold: assert property (
		ce && r_q.st == option_loader_pkg::CLR_HOLD
		&& dual_mode && !above_hi |=> hold)
		else $error("dual mode released below high threshold");
	a_dual_low: assert property (
		ce && r_q.st == option_loader_pkg::CLR_RUN
		&& above_lo |=> !hold)
		else $error("clear asserted above low threshold");
	a_single_lvl: assert property (
		ce && !dual_mode && mode_valid
		&& r_q.st == option_loader_pkg::CLR_HOLD && above_lo |=> !hold)
		else $error("single mode failed to release at low threshold");
	c_dual_rel: cover property (dual_mode && mode_valid ##1 $fell(hold));
endmodule
`default_nettype wire

// ==== shared/option_loader_pkg.sv ====
/*
 Constants and types for the reset-time option byte loader.
 Assumes byte-wide flash reads and a single system clock.
*/
// What this block does
// - Five flash bytes from the first option address configure reset-time functions.
// - Option bytes are fetched and applied automatically on every reset release.
// - With boot swap active the bytes come from the mirrored area.
// - First byte sets oscillator lock, watchdog interval, enable and window.
// - Dual-threshold mode holds reset until supply passes the higher threshold.
// - After that release, only the lower threshold asserts power-on clear.
// - Single-threshold mode holds and detects at the lower threshold only.
// - Threshold mode byte is writable only through the external programmer path.
// - Under self-programming the threshold mode falls back to single-threshold.
// - Boot swap copies the mirrored threshold mode byte into the primary byte.
// - Fifth byte selects debug off, on with erase, or on without erase.
// - Threshold byte bit 0: zero single-threshold default, one dual-threshold.
// - Debug bits: 00 off, 01 prohibited, 10 no erase, 11 erase.
// - Oscillator lock set makes software stop requests have no effect.
package option_loader_pkg;
	localparam logic [15:0] OPT_PRIMARY = 16'h0080;
	localparam logic [15:0] OPT_MIRROR = 16'h1080;
	localparam logic [15:0] OPT_THR_ADDR = 16'h0081;
	localparam logic [2:0] IDX_WD = 3'h0;
	localparam logic [2:0] IDX_THR = 3'h1;
	localparam logic [2:0] IDX_RSV0 = 3'h2;
	localparam logic [2:0] IDX_RSV1 = 3'h3;
	localparam logic [2:0] IDX_DBG = 3'h4;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int WD_LOCK_BIT = 0;
	localparam int WD_INT_LSB = 1;
	localparam int WD_ON_BIT = 4;
	localparam int WD_WIN_LO_BIT = 5;
	localparam int WD_WIN_HI_BIT = 6;
	localparam int THR_MODE_BIT = 0;
	localparam int DBG_LO_BIT = 0;
	localparam int DBG_HI_BIT = 1;
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_CONTROL = 12'h004;
	localparam logic [11:0] REG_OPT_LO = 12'h008;
	localparam logic [11:0] REG_OPT_HI = 12'h00c;
	localparam int CTRL_STOP_BIT = 0;
	localparam int STS_DONE_BIT = 0;
	localparam int STS_SWAP_BIT = 1;
	localparam int STS_SELF_BIT = 2;
	localparam int STS_CLR_BIT = 3;
	localparam int STS_RSV_BIT = 4;
	localparam int STS_BLK_BIT = 5;
	localparam int STS_DBGBAD_BIT = 6;
	typedef enum logic [2:0] {
		LD_STRAP = 3'b000,
		LD_REQ = 3'b001,
		LD_WAIT = 3'b010,
		LD_COPY = 3'b011,
		LD_RUN = 3'b100
	} load_state_type;
	typedef enum logic {
		CLR_HOLD = 1'b0,
		CLR_RUN = 1'b1
	} clr_state_type;
endpackage

// ==== tb/flash_model.sv ====
/*
 Behavioural flash holding the primary and mirrored option bytes.
 Assumes one byte read at a time on pclk; answers after 1 to 4 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fl_rd_req,
	input wire logic [15:0] fl_rd_addr,
	output logic [7:0] fl_rd_data,
	output logic fl_rd_valid,
	input wire logic fl_wr_req,
	input wire logic [15:0] fl_wr_addr,
	input wire logic [7:0] fl_wr_data
);
	logic [7:0] pri [5];
	logic [7:0] mir [5];
	logic [15:0] addr;
	int cnt;
	int seed = 29823;
	// Programs both copies alike, reserved bytes zero
	task automatic store(input logic [7:0] b0, input logic [7:0] b1,
		input logic [7:0] b4);
		pri = '{b0, b1, 8'h00, 8'h00, b4};
		mir = pri;
	endtask
	// Byte at an option address; anything else reads as junk
	function automatic logic [7:0] fetch(input logic [15:0] a);
		if (a[15:3] == 13'h0010 && a[2:0] < 3'h5) return pri[a[2:0]];
		if (a[15:3] == 13'h0210 && a[2:0] < 3'h5) return mir[a[2:0]];
		return 8'hee;
	endfunction
	// Delayed answer; data lines toggle when not answering
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			fl_rd_valid <= 1'b0;
			fl_rd_data <= 8'h5a;
		end else begin
			fl_rd_valid <= 1'b0;
			fl_rd_data <= ~fl_rd_data;
			if (fl_rd_req === 1'b1) begin
				addr <= fl_rd_addr;
				cnt <= 1 + ($random(seed) & 3);
			end else if (cnt == 1) begin
				fl_rd_valid <= 1'b1;
				fl_rd_data <= fetch(addr);
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
			if (fl_wr_req === 1'b1 && fl_wr_addr == 16'h0081) begin
				pri[1] <= fl_wr_data;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 Self-checking bench for the option byte loader.
 Assumes the flash model on the read port and APB driven from here.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, boot_swap = 1'b0, self_prog = 1'b0;
	logic fl_rd_req, fl_rd_valid, fl_wr_req, wr_in_req = 1'b0;
	logic [15:0] fl_rd_addr, fl_wr_addr, wr_in_addr = 16'h0;
	logic [7:0] fl_rd_data, fl_wr_data, wr_in_data = 8'h0;
	logic wr_in_ext = 1'b0, supply_above_hi = 1'b0, supply_above_lo = 1'b0;
	logic power_on_clear, core_reset_n, slow_osc_stop_lock, slow_osc_stop;
	logic [2:0] wd_interval;
	logic watchdog_counter_on, wd_window_sel_hi, wd_window_sel_lo;
	logic poweron_clear_threshold_select, debug_enable_hi, debug_enable_lo;
	logic debug_erase_on_fail, m;
	logic [33:0] apb_q [$];
	logic [23:0] wr_q [$];
	logic [33:0] note;
	logic [31:0] r, cw;
	logic [7:0] b0, b4;
	int n_fail = 0, num_checks = 0, seed = 29823;
	always #4 pclk = ~pclk;
	option_byte_config_loader u_dut (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .boot_swap(boot_swap), .self_prog(self_prog),
		.fl_rd_req(fl_rd_req), .fl_rd_addr(fl_rd_addr),
		.fl_rd_data(fl_rd_data), .fl_rd_valid(fl_rd_valid),
		.wr_in_req(wr_in_req), .wr_in_addr(wr_in_addr),
		.wr_in_data(wr_in_data), .wr_in_ext(wr_in_ext),
		.fl_wr_req(fl_wr_req), .fl_wr_addr(fl_wr_addr),
		.fl_wr_data(fl_wr_data), .supply_above_hi(supply_above_hi),
		.supply_above_lo(supply_above_lo), .power_on_clear(power_on_clear),
		.core_reset_n(core_reset_n), .slow_osc_stop_lock(slow_osc_stop_lock),
		.slow_osc_stop(slow_osc_stop), .wd_interval(wd_interval),
		.watchdog_counter_on(watchdog_counter_on),
		.wd_window_sel_hi(wd_window_sel_hi),
		.wd_window_sel_lo(wd_window_sel_lo),
		.poweron_clear_threshold_select(poweron_clear_threshold_select),
		.debug_enable_hi(debug_enable_hi), .debug_enable_lo(debug_enable_lo),
		.debug_erase_on_fail(debug_erase_on_fail));
	flash_model u_flash (.pclk(pclk), .presetn(presetn),
		.fl_rd_req(fl_rd_req), .fl_rd_addr(fl_rd_addr),
		.fl_rd_data(fl_rd_data), .fl_rd_valid(fl_rd_valid),
		.fl_wr_req(fl_wr_req), .fl_wr_addr(fl_wr_addr),
		.fl_wr_data(fl_wr_data));
	task automatic end_of_test();
		if (n_fail == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic timeout();
		n_fail++;
		end_of_test();
	endtask
	// One APB transfer; the answer is judged by the monitor
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, input logic [31:0] exp, input logic err);
		int n;
		apb_q.push_back({!wr && !err, err, exp});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) timeout();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One write request into the filter
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic ext, input logic pass);
		if (pass) wr_q.push_back({a, d});
		@(posedge pclk);
		wr_in_req <= 1'b1;
		wr_in_addr <= a;
		wr_in_data <= d;
		wr_in_ext <= ext;
		@(posedge pclk);
		wr_in_req <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	// Reset pulse with straps and supply levels
	task automatic boot(input logic sw, input logic sp, input logic hi);
		@(posedge pclk);
		presetn <= 1'b0;
		boot_swap <= sw;
		self_prog <= sp;
		supply_above_hi <= hi;
		supply_above_lo <= 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic wait_core();
		int n;
		n = 0;
		while (core_reset_n !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		if (core_reset_n !== 1'b1) timeout();
	endtask
	task automatic cfg(input logic [7:0] c0, input logic md,
		input logic [7:0] c4);
		cw = {25'h0, wd_window_sel_hi, wd_window_sel_lo,
			watchdog_counter_on, wd_interval, slow_osc_stop_lock};
		check("cfg_wd", cw, {25'h0, c0[6:0]});
		cw = {31'h0, poweron_clear_threshold_select};
		check("cfg_thr", cw, {31'h0, md});
		cw = {29'h0, debug_enable_hi, debug_enable_lo, debug_erase_on_fail};
		check("cfg_dbg", cw, {29'h0, c4[1:0], &c4[1:0]});
	endtask
	// APB answers against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			note = apb_q.pop_front();
			check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
			if (note[33]) check("prdata", prdata, note[31:0]);
		end
	end
	// Flash writes against the oldest note
	always @(posedge pclk) begin
		if (fl_wr_req === 1'b1) begin
			cw = (wr_q.size() > 0) ? {8'h0, wr_q.pop_front()} : 32'hdead;
			check("fl_wr", {8'h0, fl_wr_addr, fl_wr_data}, cw);
		end
	end
	initial begin
		// Every debug code, both lock values, both threshold modes
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			b0 = {1'b0, (r[6:5] == 2'b11) ? 2'b10 : r[6:5], r[4:1], i[0]};
			if (b0[6:1] == 6'h0) b0[5] = 1'b1;
			b4 = {6'h0, i[1:0]};
			m = i[0] ^ i[1];
			u_flash.store(b0, {7'h0, m}, b4);
			boot(1'b0, 1'b0, 1'b0);
			if (m) begin
				repeat (60) @(posedge pclk);
				check("hold_dual", {31'h0, core_reset_n}, 32'h0);
				supply_above_hi <= 1'b1;
			end
			wait_core();
			cfg(b0, m, b4);
			apb(1'b0, 12'h008, 32'h0, {16'h0, 7'h0, m, b0}, 1'b0);
			apb(1'b0, 12'h00c, 32'h0, {24'h0, b4}, 1'b0);
			apb(1'b0, 12'h000, 32'h0, {25'h0, b4 == 8'h01, 6'h01}, 1'b0);
			apb(1'b1, 12'h004, 32'h1, 32'h0, 1'b0);
			repeat (2) @(posedge pclk);
			check("osc_stop", {31'h0, slow_osc_stop}, {31'h0, ~b0[0]});
			apb(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
			apb(1'b1, 12'h008, r, 32'h0, 1'b1);
			apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
			supply_above_hi <= 1'b0;
			repeat (8) @(posedge pclk);
			check("clr_hi_drop", {31'h0, power_on_clear}, 32'h0);
			cfg(b0, m, b4);
			supply_above_lo <= 1'b0;
			repeat (8) @(posedge pclk);
			check("clr_lo_drop", {31'h0, power_on_clear}, 32'h1);
		end
		// Boot swap under self-programming; mirror deliberately differs
		u_flash.store(b0, 8'h00, 8'h02);
		u_flash.mir[0] = b0 ^ 8'h10;
		u_flash.mir[1] = 8'h01;
		u_flash.mir[4] = 8'h03;
		wr_q.push_back({16'h0081, 8'h01});
		boot(1'b1, 1'b1, 1'b0);
		wait_core();
		cfg(b0 ^ 8'h10, 1'b0, 8'h03);
		wr(16'h0081, 8'h01, 1'b0, 1'b0);
		wr(16'h0081, 8'h00, 1'b1, 1'b1);
		wr(16'h0090, r[7:0], 1'b0, 1'b1);
		apb(1'b0, 12'h000, 32'h0, 32'h27, 1'b0);
		apb(1'b1, 12'h000, 32'h20, 32'h0, 1'b0);
		apb(1'b0, 12'h000, 32'h0, 32'h07, 1'b0);
		// Frozen clock enable: an unblocked write must not pass
		ce <= 1'b0;
		wr(16'h0090, 8'h3c, 1'b0, 1'b0);
		ce <= 1'b1;
		check("wr_left", 32'(wr_q.size()), 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
